/* hlc_pkg.sv */
// Package: register map, encodings and carrier structs for the heating limit config bank
//
// Notes on behaviour
// - Keep a difference/inversion retry limit: maximum recycles before retry-limited response gives up.
// - Rate-limit enable: 0 no restriction, 1 restrict modulation near difference threshold.
// - Inversion tolerated at least inverse-limit time; register accepts 0 to 64800 seconds.
// - Inversion and rise responses: 0 lockout, 1 recycle+delay, 2 recycle+delay with retry.
// - Exchanger/outlet enable: 0 off, 1 limit, 2 inversion, 3 both.
// - Inlet/exchanger enable uses the same four-value encoding.
// - Exchanger/outlet threshold 0 to 130 degrees in 0.1 degree steps.
// - Exchanger temperature-rise limit active only while its enable holds 1.
// - Keep a rise retry limit: maximum recycles due to rise-limit trips.
// - Heating pump-force 1 forces heating pump off during anticondensation; 0 unchanged.
// - Hot-water pump-force 1 forces hot-water pump off; 0 normal control.
// - Priority map: set bit gives anticondensation precedence; bits 15..5 read zero.
// - Priority bits: 4 outlet high, 3 forced rate, 2 slow start, 1 difference, 0 stack.
// - Frost anticondensation performed only while its enable holds 1.
// - Time registers accept 0 to 64800 seconds; 0xFFFF means not configured, except on the inversion tolerate time, which refuses it.
// - Heating frost protection active only while its enable is 1.
// - Hot-water frost protection active only while its enable is 1.
package hlc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Register addresses
  localparam logic [15:0] A_DT_RETRY_LIMIT = 16'h01E5;
  localparam logic [15:0] A_DT_RATE_LIMIT_ENABLE = 16'h01E6;
  localparam logic [15:0] A_INVERSION_TOLERATE_TIME = 16'h01E7;
  localparam logic [15:0] A_INVERSION_RESPONSE = 16'h01E8;
  localparam logic [15:0] A_EXCH_OUT_DT_ENABLE = 16'h01E9;
  localparam logic [15:0] A_EXCH_OUT_DT_DEGREES = 16'h01EA;
  localparam logic [15:0] A_EXCH_RISE_ENABLE = 16'h01EB;
  localparam logic [15:0] A_RISE_RESPONSE = 16'h01EC;
  localparam logic [15:0] A_RISE_RETRY_LIMIT = 16'h01ED;
  localparam logic [15:0] A_IN_EXCH_DT_ENABLE = 16'h01EE;
  localparam logic [15:0] A_IN_EXCH_DT_DEGREES = 16'h01EF;
  localparam logic [15:0] A_HEAT_ANTICOND_ENABLE = 16'h01F0;
  localparam logic [15:0] A_HEAT_ANTICOND_SETPOINT = 16'h01F1;
  localparam logic [15:0] A_HEAT_ANTICOND_PUMP_OFF = 16'h01F2;
  localparam logic [15:0] A_WATER_ANTICOND_ENABLE = 16'h01F3;
  localparam logic [15:0] A_WATER_ANTICOND_SETPOINT = 16'h01F4;
  localparam logic [15:0] A_WATER_ANTICOND_PUMP_OFF = 16'h01F5;
  localparam logic [15:0] A_ANTICOND_PRIORITY_MAP = 16'h01F6;
  localparam logic [15:0] A_FROST_ANTICOND_ENABLE = 16'h01F7;
  localparam logic [15:0] A_STORAGE_ENABLE = 16'h01F8;
  localparam logic [15:0] A_STORAGE_TIME = 16'h01F9;
  localparam logic [15:0] A_STORAGE_SETPOINT = 16'h01FA;
  localparam logic [15:0] A_STORAGE_ON_HYST = 16'h01FB;
  localparam logic [15:0] A_STORAGE_OFF_HYST = 16'h01FC;
  localparam logic [15:0] A_WATER_PRIORITY_METHOD = 16'h01FD;
  localparam logic [15:0] A_RESERVED_BLOCK_A = 16'h01FE;
  localparam logic [15:0] A_RESERVED_BLOCK_A_END = 16'h01FF;
  localparam logic [15:0] A_CURVE_MAX_OUTDOOR = 16'h0200;
  localparam logic [15:0] A_CURVE_MIN_OUTDOOR = 16'h0201;
  localparam logic [15:0] A_CURVE_LOW_WATER = 16'h0202;
  localparam logic [15:0] A_CURVE_BOOST_TIME = 16'h0203;
  localparam logic [15:0] A_CURVE_MAX_OFF_POINT = 16'h0204;
  localparam logic [15:0] A_GROUP_CURVE_MAX_OUTDOOR = 16'h0205;
  localparam logic [15:0] A_GROUP_CURVE_MIN_OUTDOOR = 16'h0206;
  localparam logic [15:0] A_GROUP_CURVE_LOW_WATER = 16'h0207;
  localparam logic [15:0] A_GROUP_CURVE_BOOST_TIME = 16'h0208;
  localparam logic [15:0] A_GROUP_CURVE_MAX_OFF = 16'h0209;
  localparam logic [15:0] A_CURVE_BOOST_STEP = 16'h020A;
  localparam logic [15:0] A_CURVE_RECOVERY_STEP_TIME = 16'h020B;
  localparam logic [15:0] A_GROUP_CURVE_BOOST_STEP = 16'h020C;
  localparam logic [15:0] A_GROUP_CURVE_RECOVERY_TIME = 16'h020D;
  localparam logic [15:0] A_MIN_WATER_TEMP = 16'h020E;
  localparam logic [15:0] A_GROUP_CURVE_MIN_WATER = 16'h020F;
  localparam logic [15:0] A_HEAT_FROST_ENABLE = 16'h0210;
  localparam logic [15:0] A_WATER_FROST_ENABLE = 16'h0211;
  localparam logic [15:0] A_OUTDOOR_FROST_SETPOINT = 16'h0212;
  localparam logic [15:0] A_RESERVED_BLOCK_B = 16'h0213;

  // Bank window and storage size
  localparam logic [15:0] A_FIRST = 16'h01E5;
  localparam logic [15:0] A_LAST = 16'h0213;
  localparam int NUM_SLOTS = 47;

  // Reset value of every register (none documented)
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // Limits and sentinels
  localparam logic [15:0] TIME_MAX_S = 16'hFD20;
  localparam logic [15:0] NOT_CONFIGURED = 16'hFFFF;
  localparam logic [15:0] DEGREES_MAX = 16'h0514;
  localparam logic [15:0] PRIORITY_MASK = 16'h001F;

  // Priority map bit positions
  localparam int PRI_STACK = 0;
  localparam int PRI_DIFF = 1;
  localparam int PRI_SLOW_START = 2;
  localparam int PRI_FORCED_RATE = 3;
  localparam int PRI_OUTLET_HIGH = 4;

  // Response encodings
  typedef enum logic [1:0] {
    HLC_RESP_LOCKOUT = 2'b00,
    HLC_RESP_RECYCLE = 2'b01,
    HLC_RESP_RETRY = 2'b10,
    HLC_RESP_BAD = 2'b11
  } hlc_resp_e;

  // Difference-limit enable encodings
  typedef enum logic [1:0] {
    HLC_DT_OFF = 2'b00,
    HLC_DT_LIMIT = 2'b01,
    HLC_DT_INVERSION = 2'b10,
    HLC_DT_BOTH = 2'b11
  } hlc_dt_e;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hlc_req_s;

  // Decoded settings for downstream control logic
  typedef struct packed {
    logic dt_rate_limit;
    logic exch_out_limit;
    logic exch_out_inversion;
    logic in_exch_limit;
    logic in_exch_inversion;
    logic rise_limit;
    hlc_resp_e inversion_resp;
    hlc_resp_e rise_resp;
    logic heat_pump_force_off;
    logic water_pump_force_off;
    logic [4:0] priority_map;
    logic frost_anticond;
    logic heat_frost;
    logic water_frost;
  } hlc_cfg_s;

endpackage : hlc_pkg

/* hlc_bank.sv */
// Module: heating limit configuration register bank with decoded settings
`timescale 1ns/1ns
module hlc_bank #(
  parameter int NUM_SLOTS = hlc_pkg::NUM_SLOTS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hlc_pkg::hlc_req_s req,
  output hlc_pkg::hlc_req_s unused_echo,
  output logic rvalid,
  output logic wack,
  output logic wrejected,
  output logic [15:0] rdata,
  output hlc_pkg::hlc_cfg_s cfg
);

  // Storage: one word per address of the window
  logic [15:0] regs [NUM_SLOTS];
  logic [15:0] next_rdata;
  logic [5:0] idx;
  logic in_window;
  logic is_reserved;
  logic is_time;
  logic is_degrees;
  logic is_two_bit;
  logic is_one_bit;
  logic is_response;
  logic value_ok;
  logic [15:0] stored_value;
  hlc_pkg::hlc_cfg_s next_cfg;

  // Classify registers by value domain
  function automatic logic match_time(input logic [15:0] a);
    match_time = (a == hlc_pkg::A_STORAGE_TIME) || (a == hlc_pkg::A_CURVE_BOOST_TIME)
      || (a == hlc_pkg::A_GROUP_CURVE_BOOST_TIME) || (a == hlc_pkg::A_CURVE_RECOVERY_STEP_TIME)
      || (a == hlc_pkg::A_GROUP_CURVE_RECOVERY_TIME);
  endfunction : match_time

  function automatic logic match_one_bit(input logic [15:0] a);
    match_one_bit = (a == hlc_pkg::A_DT_RATE_LIMIT_ENABLE) || (a == hlc_pkg::A_EXCH_RISE_ENABLE)
      || (a == hlc_pkg::A_HEAT_ANTICOND_ENABLE) || (a == hlc_pkg::A_HEAT_ANTICOND_PUMP_OFF)
      || (a == hlc_pkg::A_WATER_ANTICOND_ENABLE) || (a == hlc_pkg::A_WATER_ANTICOND_PUMP_OFF)
      || (a == hlc_pkg::A_FROST_ANTICOND_ENABLE) || (a == hlc_pkg::A_STORAGE_ENABLE)
      || (a == hlc_pkg::A_WATER_PRIORITY_METHOD) || (a == hlc_pkg::A_HEAT_FROST_ENABLE)
      || (a == hlc_pkg::A_WATER_FROST_ENABLE);
  endfunction : match_one_bit

  // Address decode
  assign in_window = (req.addr >= hlc_pkg::A_FIRST) && (req.addr <= hlc_pkg::A_LAST);
  assign idx = in_window ? 6'(req.addr - hlc_pkg::A_FIRST) : 6'h00;
  assign is_reserved = ((req.addr >= hlc_pkg::A_RESERVED_BLOCK_A) && (req.addr <= hlc_pkg::A_RESERVED_BLOCK_A_END))
    || (req.addr == hlc_pkg::A_RESERVED_BLOCK_B);
  assign is_time = match_time(req.addr) || (req.addr == hlc_pkg::A_INVERSION_TOLERATE_TIME);
  assign is_degrees = (req.addr == hlc_pkg::A_EXCH_OUT_DT_DEGREES) || (req.addr == hlc_pkg::A_IN_EXCH_DT_DEGREES);
  assign is_two_bit = (req.addr == hlc_pkg::A_EXCH_OUT_DT_ENABLE) || (req.addr == hlc_pkg::A_IN_EXCH_DT_ENABLE);
  assign is_response = (req.addr == hlc_pkg::A_INVERSION_RESPONSE) || (req.addr == hlc_pkg::A_RISE_RESPONSE);
  assign is_one_bit = match_one_bit(req.addr);

  // Range check of written values; out-of-range writes leave the register untouched
  assign value_ok = is_time ? ((req.wdata <= hlc_pkg::TIME_MAX_S) ||
      ((req.wdata == hlc_pkg::NOT_CONFIGURED) && match_time(req.addr))) :
    is_degrees ? (req.wdata <= hlc_pkg::DEGREES_MAX) :
    is_two_bit ? (req.wdata[15:2] == 14'h0000) :
    is_response ? (req.wdata <= 16'h0002) :
    is_one_bit ? (req.wdata[15:1] == 15'h0000) :
    1'b1; // retry limits and temperatures take any value

  // Priority map keeps bits 15..5 at zero
  assign stored_value = (req.addr == hlc_pkg::A_ANTICOND_PRIORITY_MAP) ?
    (req.wdata & hlc_pkg::PRIORITY_MASK) : req.wdata;

  // Read mux; reserved and unmapped addresses read zero
  assign next_rdata = (in_window && !is_reserved) ? regs[idx] : 16'h0000;

  // Register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs[i] <= hlc_pkg::RST_VALUE;
      end
    end else if (req.wr && in_window && !is_reserved && value_ok) begin
      regs[idx] <= stored_value;
    end
  end

  // Read and write answers, one cycle after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      wack <= 1'b0;
      wrejected <= 1'b0;
      rdata <= 16'h0000;
      unused_echo <= '0;
    end else begin
      rvalid <= req.rd;
      wack <= req.wr;
      wrejected <= req.wr && in_window && !is_reserved && !value_ok;
      rdata <= req.rd ? next_rdata : 16'h0000;
      unused_echo <= req;
    end
  end

  // Settings decode for the control logic
  assign next_cfg.dt_rate_limit = regs[6'(hlc_pkg::A_DT_RATE_LIMIT_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.exch_out_limit = regs[6'(hlc_pkg::A_EXCH_OUT_DT_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.exch_out_inversion = regs[6'(hlc_pkg::A_EXCH_OUT_DT_ENABLE - hlc_pkg::A_FIRST)][1];
  assign next_cfg.in_exch_limit = regs[6'(hlc_pkg::A_IN_EXCH_DT_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.in_exch_inversion = regs[6'(hlc_pkg::A_IN_EXCH_DT_ENABLE - hlc_pkg::A_FIRST)][1];
  assign next_cfg.rise_limit = regs[6'(hlc_pkg::A_EXCH_RISE_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.inversion_resp =
    hlc_pkg::hlc_resp_e'(regs[6'(hlc_pkg::A_INVERSION_RESPONSE - hlc_pkg::A_FIRST)][1:0]);
  assign next_cfg.rise_resp = hlc_pkg::hlc_resp_e'(regs[6'(hlc_pkg::A_RISE_RESPONSE - hlc_pkg::A_FIRST)][1:0]);
  assign next_cfg.heat_pump_force_off = regs[6'(hlc_pkg::A_HEAT_ANTICOND_PUMP_OFF - hlc_pkg::A_FIRST)][0];
  assign next_cfg.water_pump_force_off = regs[6'(hlc_pkg::A_WATER_ANTICOND_PUMP_OFF - hlc_pkg::A_FIRST)][0];
  assign next_cfg.priority_map = regs[6'(hlc_pkg::A_ANTICOND_PRIORITY_MAP - hlc_pkg::A_FIRST)][4:0];
  assign next_cfg.frost_anticond = regs[6'(hlc_pkg::A_FROST_ANTICOND_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.heat_frost = regs[6'(hlc_pkg::A_HEAT_FROST_ENABLE - hlc_pkg::A_FIRST)][0];
  assign next_cfg.water_frost = regs[6'(hlc_pkg::A_WATER_FROST_ENABLE - hlc_pkg::A_FIRST)][0];

  // Registered settings so outputs come from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

endmodule : hlc_bank

/* hlc_bank_checker.sv */
// Checker: port-level assertions for the heating limit config bank
`timescale 1ns/1ns
module hlc_bank_checker #(
  parameter int NUM_SLOTS = hlc_pkg::NUM_SLOTS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hlc_pkg::hlc_req_s req,
  input wire hlc_pkg::hlc_req_s unused_echo,
  input wire logic rvalid,
  input wire logic wack,
  input wire logic wrejected,
  input wire logic [15:0] rdata,
  input wire hlc_pkg::hlc_cfg_s cfg
);
  // Reserved slots inside the bank window
  wire rsv = (req.addr == 16'h01FE) || (req.addr == 16'h01FF) || (req.addr == 16'h0213);
  wire wr_at = req.wr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Answers land exactly one cycle after the request
  a_read_answer: assert property (req.rd |=> rvalid) else $error("read not answered");
  a_write_ack: assert property (wr_at |=> wack) else $error("write not acknowledged");
  // Debug echo is the request of the previous edge; skipped on the edge after reset
  a_echo_copy: assert property (!$past(rst) |-> unused_echo == $past(req))
    else $error("request echo wrong");
  a_rsv_read: assert property (req.rd && rsv |=> rdata == 16'h0000) else $error("reserved read not zero");
  a_rsv_write: assert property (wr_at && rsv |=> !wrejected) else $error("reserved write rejected");
  a_pri_upper: assert property (req.rd && req.addr == 16'h01F6 |=> rdata[15:5] == 11'h000)
    else $error("priority upper bits set");
  // Decoded settings follow a write two cycles later
  a_heat_pump: assert property (wr_at && req.addr == 16'h01F2 && req.wdata == 16'h0001 |-> ##2 cfg.heat_pump_force_off)
    else $error("heating pump not forced off");
  a_water_pump: assert property (wr_at && req.addr == 16'h01F5 && req.wdata == 16'h0000 |-> ##2 !cfg.water_pump_force_off)
    else $error("hot-water pump forced off");
  a_inv_time: assert property (wr_at && req.addr == 16'h01E7 && req.wdata > 16'hFD20 |=> wrejected)
    else $error("long inversion time kept");
  a_resp_code: assert property (wr_at && req.addr == 16'h01E8 && req.wdata <= 16'h0002
    |-> ##2 cfg.inversion_resp == $past(req.wdata[1:0], 2)) else $error("inversion response wrong");
  a_store_time: assert property (wr_at && req.addr == 16'h01F9 && req.wdata == 16'hFFFF |=> !wrejected)
    else $error("not-configured time refused");
  a_dt_enable: assert property (wr_at && req.addr == 16'h01E9 && req.wdata <= 16'h0003
    |-> ##2 {cfg.exch_out_inversion, cfg.exch_out_limit} == $past(req.wdata[1:0], 2))
    else $error("difference enable decode wrong");
endmodule : hlc_bank_checker

bind hlc_bank hlc_bank_checker #(.NUM_SLOTS(NUM_SLOTS)) u_chk (.mclk(mclk), .rst(rst), .req(req),
  .unused_echo(unused_echo), .rvalid(rvalid),
  .wack(wack), .wrejected(wrejected), .rdata(rdata), .cfg(cfg));

/* hlc_master.sv */
// Partner model: register-bus master issuing one-cycle requests
`timescale 1ns/1ns
module hlc_master (
  input wire logic mclk,
  output hlc_pkg::hlc_req_s req
);
  initial req = '0;
  // One request, then an idle cycle; idle fields carry inverted junk so stale values never look valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= {w, ~w, a, d};
    @(posedge mclk);
    req <= {1'b0, 1'b0, ~a, ~d};
  endtask : xfer
endmodule : hlc_master

/* hlc_bank_tb.sv */
// Testbench: self-checking run of the heating limit config bank
`timescale 1ns/1ns
module hlc_bank_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  hlc_pkg::hlc_req_s req;
  hlc_pkg::hlc_cfg_s cfg;
  logic rvalid, wack, wrejected;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [15:0] mdl [16'h01E5:16'h0213];
  logic [15:0] rq[$];
  logic wq[$];
  int n_mismatch = 0;
  int compares = 0;
  integer seed = 32'hD7B22453;
  // Writes as address, data, rejected flag
  logic [35:0] tbl [0:26] = '{36'h01E5_FFFF_0,
    36'h01E6_0002_1, 36'h01E6_0001_0,
    36'h01E7_FD20_0, 36'h01E7_FD21_1, 36'h01E7_FFFF_1,
    36'h01E8_0003_1, 36'h01E8_0002_0, 36'h01EC_0000_0,
    36'h01E9_0004_1, 36'h01E9_0003_0, 36'h01EE_0001_0,
    36'h01EA_0514_0, 36'h01EA_0515_1, 36'h01EB_0001_0, 36'h01ED_1234_0,
    36'h01F2_0001_0, 36'h01F5_0000_0, 36'h01F5_0001_0, 36'h01F6_FFFF_0,
    36'h01F7_0001_0, 36'h01F9_FFFF_0, 36'h0203_FD21_1,
    36'h0210_0001_0, 36'h0211_0001_0, 36'h01FE_1234_0, 36'h0213_5555_0};

  always #10 mclk = ~mclk;

  hlc_master u_m (.mclk(mclk), .req(req));
  hlc_bank uut (.mclk(mclk), .rst(rst), .req(req), .unused_echo(), .rvalid(rvalid), .wack(wack),
    .wrejected(wrejected), .rdata(rdata), .cfg(cfg));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Note the expected outcome, track stored value, then issue
  task automatic wr(input logic [15:0] a, input logic [15:0] dv, input logic rej);
    wq.push_back(rej);
    if (!rej && a != 16'h01FE && a != 16'h01FF && a != 16'h0213) mdl[a] = (a == 16'h01F6) ? (dv & 16'h001F) : dv;
    u_m.xfer(1'b1, a, dv);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    rq.push_back((a >= 16'h01E5 && a <= 16'h0213) ? mdl[a] : 16'h0000);
    u_m.xfer(1'b0, a, 16'h0000);
  endtask : rd

  task automatic close_out;
    // Notes left unanswered mean a lost response
    if (rq.size() != 0 || wq.size() != 0) n_mismatch++;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Pair each answer with the oldest note
  always @(posedge mclk) begin
    if (wack) check({15'h0000, wrejected}, {15'h0000, wq.pop_front()});
    if (rvalid) check(rdata, rq.pop_front());
  end

  // Main sequence
  initial begin
    for (int i = 16'h01E5; i <= 16'h0213; i++) mdl[i] = 16'h0000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 16'h01E5; i <= 16'h0213; i++) rd(i[15:0]);
    rd(16'h0100);
    foreach (tbl[i]) begin
      wr(tbl[i][35:20], tbl[i][19:4], tbl[i][0]);
      rd(tbl[i][35:20]);
    end
    repeat (3) @(posedge mclk);
    // Slices follow the packed order of the settings struct, widened on purpose
    check(16'(cfg[19:15]), 16'h001E);
    check(16'(cfg[14:10]), 16'h0018);
    check(16'(cfg[9:3]), 16'h007F);
    check(16'(cfg[2:0]), 16'h0007);
    // Random retry limits, any value is legal
    repeat (20) begin
      d = 16'($random(seed));
      wr(16'h01ED, d, 1'b0);
      rd(16'h01ED);
    end
    // Second reset in mid-run clears the bank
    repeat (3) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 16'h01E5; i <= 16'h0213; i++) mdl[i] = 16'h0000;
    rd(16'h01F2);
    repeat (4) @(posedge mclk);
    // Every decoded setting falls back to disabled after reset
    check({15'h0000, |cfg}, 16'h0000);
    close_out;
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule : hlc_bank_tb
